// ### hdl/mwu_defines.vh
// Functional notes
// [RL1] Edge-select bit n picks polarity of wake input n: 0 rising, 1 falling.
// [RL2] Reset clears edge-select so all sixteen inputs detect rising edges.
// [RL3] Enable bit n gates wake-up and interrupt of channel n.
// [RL4] Reset clears enable register, all channels disabled.
// [RL5] Low routing register: eight 2-bit fields for inputs 0..7, resets zero.
// [RL6] High routing register: eight 2-bit fields for inputs 8..15, resets zero.
// [RL7] Routing code 00..11 selects interrupt request line 0..3.
// [RL8] Selected edge sets pending bit, held until cleared; reset clears all.
// [RL9] Writing 1 to pending sets the bit; writing 0 has no effect.
// [RL10] Pending-clear is write-only; writing 1 clears that pending bit.
// [RL11] Pending-clear reads are undefined; software writes the mask directly.
// [RL12] Software setup order: disable, inputs, polarity, clear, route, enable.
// [RL13] Polarity change: disable, write polarity, clear pending, re-enable.
// [RL14] Enabled pending channel raises wake request and its routed request line.
// [RL15] Edge detection and latching keep working with the system clock stopped; here only the toggle flops run, pending latches on ref_clk.
// [RL16] Asynchronous pending bits are synchronized before reads and outputs.
// [RL17] A trigger wins over a coinciding clear so no event is lost.
`ifndef MWU_DEFINES_VH
`define MWU_DEFINES_VH
`define MWU_ADDR_EDGE    4'h0
`define MWU_ADDR_ENABLE  4'h1
`define MWU_ADDR_RLOW    4'h2
`define MWU_ADDR_RHIGH   4'h3
`define MWU_ADDR_PEND    4'h4
`define MWU_ADDR_PCLR    4'h5
`define MWU_ADDR_ISTAT   4'h6
`define MWU_ADDR_IENA    4'h7
`define MWU_ADDR_ICLR    4'h8
`define MWU_RST_WORD     16'h0000
`define MWU_RST_IRQ      4'h0
`endif

// ### hdl/mwu_top.v
`timescale 1ns/1ps
`include "mwu_defines.vh"
module mwu_top #(
   parameter NCH = 16
) (
   // Clock and reset.
   input  wire        ref_clk,
   input  wire        resetn,
   // Register port.
   input  wire [3:0]  reg_addr,
   input  wire [15:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [15:0] reg_rdata,
   // Wake inputs from pins and peripherals.
   input  wire [15:0] wake_in,
   // Requests toward power management and the interrupt control unit.
   output reg         wake_req,
   output reg  [3:0]  irq_line,
   output wire        irq
);

   // =========================================================================
   // Reset release.
   reg        rst_a_ff;
   reg        rst_b_ff;
   wire       rstn;

   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_a_ff <= 1'b0;
         rst_b_ff <= 1'b0;
      end else begin
         rst_a_ff <= 1'b1;
         rst_b_ff <= rst_a_ff;
      end
   end
   assign rstn = rst_b_ff;

   // =========================================================================
   // Register decode.
   // One address compare serves both the write and the read decode.
   function hit;
      input [3:0] addr;
      input [3:0] sel;
      begin
         hit = (addr == sel);
      end
   endfunction

   wire        wr_edge  = reg_wr && hit(reg_addr, `MWU_ADDR_EDGE);
   wire        wr_ena   = reg_wr && hit(reg_addr, `MWU_ADDR_ENABLE);
   wire        wr_rlow  = reg_wr && hit(reg_addr, `MWU_ADDR_RLOW);
   wire        wr_rhigh = reg_wr && hit(reg_addr, `MWU_ADDR_RHIGH);
   wire        wr_pend  = reg_wr && hit(reg_addr, `MWU_ADDR_PEND);
   wire        wr_pclr  = reg_wr && hit(reg_addr, `MWU_ADDR_PCLR);
   wire        wr_iena  = reg_wr && hit(reg_addr, `MWU_ADDR_IENA);
   wire        wr_iclr  = reg_wr && hit(reg_addr, `MWU_ADDR_ICLR);

   // =========================================================================
   // Configuration registers.
   reg  [15:0] edge_ff;
   reg  [15:0] ena_ff;
   reg  [15:0] rlow_ff;
   reg  [15:0] rhigh_ff;
   reg  [3:0]  irq_stat_ff;
   reg  [3:0]  irq_ena_ff;

   // Each register has its own write strobe from the shared decode.
   // Edge select, rising edges after reset.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         edge_ff <= `MWU_RST_WORD; // [RL2]
      end else if (wr_edge) begin
         edge_ff <= reg_wdata; // [RL1]
      end
   end

   // Channel enable, all channels off after reset.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ena_ff <= `MWU_RST_WORD; // [RL4]
      end else if (wr_ena) begin
         ena_ff <= reg_wdata; // [RL3]
      end
   end

   // Routing fields of channels 0 to 7.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rlow_ff <= `MWU_RST_WORD; // [RL5]
      end else if (wr_rlow) begin
         rlow_ff <= reg_wdata; // [RL5]
      end
   end

   // Routing fields of channels 8 to 15.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rhigh_ff <= `MWU_RST_WORD; // [RL6]
      end else if (wr_rhigh) begin
         rhigh_ff <= reg_wdata; // [RL6]
      end
   end

   // Interrupt enable of the four request lines.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_ena_ff <= `MWU_RST_IRQ;
      end else if (wr_iena) begin
         irq_ena_ff <= reg_wdata[3:0];
      end
   end

   // =========================================================================
   // Per-channel edge capture; the toggle flops run without the system clock, the synchronizers on ref_clk.
   wire [15:0] rise_tog;
   wire [15:0] fall_tog;
   wire [15:0] trig_evt;

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_ch
         reg       rise_tog_ff;
         reg       fall_tog_ff;
         reg [2:0] rise_sync_ff;
         reg [2:0] fall_sync_ff;
         wire      rise_evt;
         wire      fall_evt;

         // Rising edges toggle this flop, even with the system clock stopped.
         // Both edges are kept, so the polarity bit only chooses between them.
         always @(posedge wake_in[g] or negedge rstn) begin
            if (!rstn) begin
               rise_tog_ff <= 1'b0;
            end else begin
               rise_tog_ff <= ~rise_tog_ff; // [RL15]
            end
         end

         // Falling edges toggle this flop in the same way.
         always @(negedge wake_in[g] or negedge rstn) begin
            if (!rstn) begin
               fall_tog_ff <= 1'b0;
            end else begin
               fall_tog_ff <= ~fall_tog_ff; // [RL15]
            end
         end

         assign rise_tog[g] = rise_tog_ff;
         assign fall_tog[g] = fall_tog_ff;

         // Three flops per toggle; a change counts when the last two differ.
         always @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               rise_sync_ff <= 3'b000;
               fall_sync_ff <= 3'b000;
            end else begin
               rise_sync_ff <= {rise_sync_ff[1:0], rise_tog[g]}; // [RL16]
               fall_sync_ff <= {fall_sync_ff[1:0], fall_tog[g]}; // [RL16]
            end
         end

         assign rise_evt = rise_sync_ff[2] ^ rise_sync_ff[1];
         assign fall_evt = fall_sync_ff[2] ^ fall_sync_ff[1];

         // Only the edge picked by the polarity bit sets pending, so a
         // polarity write cannot itself make a trigger.
         assign trig_evt[g] = edge_ff[g] ? fall_evt : rise_evt; // [RL1] [RL8]
      end
   endgenerate

   // =========================================================================
   // Pending word kept in the system clock domain. [RL16]
   reg  [15:0] pend_ff;
   wire [15:0] clr_mask = wr_pclr ? reg_wdata : 16'h0000;
   wire [15:0] set_mask = wr_pend ? reg_wdata : 16'h0000;
   wire [15:0] nxt_pend = (pend_ff & ~clr_mask) | set_mask | trig_evt; // [RL9] [RL10] [RL17]

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pend_ff <= `MWU_RST_WORD; // [RL8]
      end else begin
         pend_ff <= nxt_pend;
      end
   end

   // =========================================================================
   // Routing and request outputs.
   function [1:0] route_of;
      input [15:0] lo;
      input [15:0] hi;
      input [3:0]  ch;
      begin
         if (ch[3]) begin
            route_of = hi[{ch[2:0], 1'b0} +: 2];
         end else begin
            route_of = lo[{ch[2:0], 1'b0} +: 2];
         end
      end
   endfunction

   reg [3:0]  nxt_irq_line;
   wire [15:0] active = pend_ff & ena_ff; // [RL3]
   integer i;

   always @* begin
      nxt_irq_line = 4'h0;
      for (i = 0; i < NCH; i = i + 1) begin
         if (active[i]) begin
            nxt_irq_line[route_of(rlow_ff, rhigh_ff, i[3:0])] = 1'b1; // [RL7] [RL14]
         end
      end
   end

   // =========================================================================
   // Request outputs toward power management and the interrupt unit.
   // Wake request follows any enabled pending channel.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= |active; // [RL14]
      end
   end

   // Line k is high while an enabled pending channel routed to it is set.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_line <= `MWU_RST_IRQ;
      end else begin
         irq_line <= nxt_irq_line; // [RL14]
      end
   end

   // =========================================================================
   // Interrupt status: a rising request line sets its bit and beats a clear.
   wire [3:0] line_rise = nxt_irq_line & ~irq_line;
   wire [3:0] icl_mask  = wr_iclr ? reg_wdata[3:0] : 4'h0;

   // Status clears only through the clear register.
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_ff <= `MWU_RST_IRQ;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~icl_mask) | line_rise;
      end
   end

   assign irq = |(irq_stat_ff & irq_ena_ff);

   // =========================================================================
   // Read select strobes.
   wire        rd_edge  = reg_rd && hit(reg_addr, `MWU_ADDR_EDGE);
   wire        rd_ena   = reg_rd && hit(reg_addr, `MWU_ADDR_ENABLE);
   wire        rd_rlow  = reg_rd && hit(reg_addr, `MWU_ADDR_RLOW);
   wire        rd_rhigh = reg_rd && hit(reg_addr, `MWU_ADDR_RHIGH);
   wire        rd_pend  = reg_rd && hit(reg_addr, `MWU_ADDR_PEND);
   wire        rd_istat = reg_rd && hit(reg_addr, `MWU_ADDR_ISTAT);
   wire        rd_iena  = reg_rd && hit(reg_addr, `MWU_ADDR_IENA);

   // =========================================================================
   // Read data, valid in the cycle after the read strobe and zero otherwise.
   // Pending-clear and unmapped locations read as zero. [RL11]
   reg  [15:0] nxt_rdata;

   always @* begin
      nxt_rdata = 16'h0000;
      if (rd_edge) begin
         nxt_rdata = edge_ff;
      end
      if (rd_ena) begin
         nxt_rdata = ena_ff;
      end
      if (rd_rlow) begin
         nxt_rdata = rlow_ff;
      end
      if (rd_rhigh) begin
         nxt_rdata = rhigh_ff;
      end
      if (rd_pend) begin
         nxt_rdata = pend_ff; // [RL16]
      end
      if (rd_istat) begin
         nxt_rdata = {12'h000, irq_stat_ff};
      end
      if (rd_iena) begin
         nxt_rdata = {12'h000, irq_ena_ff};
      end
   end

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= `MWU_RST_WORD;
      end else begin
         reg_rdata <= nxt_rdata;
      end
   end

endmodule // mwu_top

// ### sim/mwu_chk.sv
`timescale 1ns/1ps
// ==========
// Checker on the register port and request outputs.
module mwu_chk (
   // Clock and reset.
   input wire        ref_clk,
   input wire        resetn,
   // Register port.
   input wire [3:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata,
   // Wake inputs and requests.
   input wire [15:0] wake_in,
   input wire        wake_req,
   input wire [3:0]  irq_line,
   input wire        irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside read cycle");
   a_pclr_read_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5 |-> reg_rdata == 16'h0000)
      else $error("pending clear read not zero");
   a_wake_line_tie: assert property (wake_req == (|irq_line))
      else $error("wake request and request lines disagree");
   a_edge_read_back: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && !reg_wr && reg_addr == 4'h0 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("edge select read back");
   a_enable_read_back: assert property (reg_wr && reg_addr == 4'h1 ##1 reg_rd && !reg_wr && reg_addr == 4'h1 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("enable read back");
   a_rlow_read_back: assert property (reg_wr && reg_addr == 4'h2 ##1 reg_rd && !reg_wr && reg_addr == 4'h2 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("route low read back");
   a_rhigh_read_back: assert property (reg_wr && reg_addr == 4'h3 ##1 reg_rd && !reg_wr && reg_addr == 4'h3 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("route high read back");
   a_disable_quiet: assert property (reg_wr && reg_addr == 4'h1 && reg_wdata == 16'h0000 |-> ##2 !wake_req && irq_line == 4'h0)
      else $error("request while all channels disabled");
endmodule // mwu_chk
bind mwu_top mwu_chk i_mwu_chk (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .wake_in, .wake_req, .irq_line, .irq);

// ### sim/mwu_icu_model.sv
`timescale 1ns/1ps
// ==========
// Interrupt unit model that records every request line it has seen high.
module mwu_icu_model (
   // Clock and request lines.
   input  wire        ref_clk,
   input  wire  [3:0] irq_line,
   // Lines seen raised.
   output logic [3:0] seen
);
   initial seen = 4'h0;
   always @(posedge ref_clk) seen <= seen | irq_line;
endmodule // mwu_icu_model

// ### sim/tb_multi_input_wakeup_unit.sv
`timescale 1ns/1ps
// ==========
// Testbench top.
module tb_multi_input_wakeup_unit;
   logic        ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, wake_in = 16'h0000;
   wire  [15:0] reg_rdata;
   wire  [3:0]  irq_line, seen;
   wire         wake_req, irq;
   int          err_count = 0, compares = 0;
   always #25 ref_clk = ~ref_clk;
   mwu_top i_mwu_top (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .wake_in, .wake_req, .irq_line, .irq);
   mwu_icu_model i_mwu_icu_model (.ref_clk, .irq_line, .seen);
   task chk(input logic [15:0] s, input logic [15:0] e, input string n);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      chk(reg_rdata, e, "read data");
   endtask
   task t_route;
      logic [31:0] r;
      for (int a = 0; a < 5; a++) rd(a[3:0], 16'h0000);
      wr(4'h7, 16'h0007);
      for (int k = 0; k < 4; k++) begin
         r = k << (10 * k);
         wr(4'h1, 16'h0000);
         wr(4'h5, 16'hffff);
         wr(4'h2, r[15:0]);
         wr(4'h3, r[31:16]);
         wr(4'h8, 16'h000f);
         wr(4'h1, 16'h0001 << (5 * k));
         wake_in[5 * k] <= 1'b1;
         repeat (8) @(posedge ref_clk);
         rd(4'h4, 16'h0001 << (5 * k));
         chk({12'h000, irq_line}, 16'h0001 << k, "request line");
         chk({15'h0000, wake_req}, 16'h0001, "wake request");
         chk({15'h0000, irq}, {15'h0000, k != 3}, "interrupt");
         rd(4'h6, 16'h0001 << k);
         @(posedge ref_clk);
         wake_in[5 * k] <= 1'b0;
         wr(4'h5, 16'h0001 << (5 * k));
         repeat (6) @(posedge ref_clk);
         chk({12'h000, irq_line}, 16'h0000, "request line");
      end
      chk({12'h000, seen}, 16'h000f, "lines seen");
      $display("routing test done");
   endtask
   task t_pend;
      wr(4'h1, 16'h0000);
      wr(4'h0, 16'h0002);
      wr(4'h5, 16'hffff);
      wr(4'h1, 16'h0002);
      wake_in[1] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(4'h4, 16'h0000);
      @(posedge ref_clk);
      wake_in[1] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd(4'h4, 16'h0002);
      wr(4'h1, 16'h0000);
      wr(4'h5, 16'hffff);
      wr(4'h4, 16'h8000);
      wr(4'h4, 16'h0000);
      repeat (6) @(posedge ref_clk);
      rd(4'h4, 16'h8000);
      rd(4'h5, 16'h0000);
      rd(4'hf, 16'h0000);
      $display("pending test done");
   endtask
   task t_readback;
      for (int a = 0; a < 4; a++) begin
         @(posedge ref_clk);
         reg_addr <= a[3:0];
         reg_wdata <= 16'h1234 << a;
         reg_wr <= 1'b1;
         @(posedge ref_clk);
         reg_wr <= 1'b0;
         reg_rd <= 1'b1;
         @(posedge ref_clk);
         reg_rd <= 1'b0;
         @(negedge ref_clk);
         chk(reg_rdata, 16'h1234 << a, "read back");
      end
      $display("readback test done");
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_route;
      t_pend;
      t_readback;
      stop_test;
   end
   initial begin
      #200000;
      err_count++;
      stop_test;
   end
endmodule // tb_multi_input_wakeup_unit
